//--- verilog/cfg_load_map.svh
`ifndef CFG_LOAD_MAP_SVH
`define CFG_LOAD_MAP_SVH
// Purpose: Named timing counts, masks and widths of the parallel load host.
// Assumes: sys_clk at 250 MHz.
// Notes:   Times are kept in their printed units; cycle counts derive from them.
`define SYS_PERIOD_NS   4
`define REQ_LOW_NS      2000
`define STATUS_GAP_NS   2000
`define REQ_TO_EDGE_US  1506
`define LOAD_HALF_CYC   2
`define FINAL_FALLS     2
`define CNT_W           20
`define LANES_8         32'h000000ff
`define LANES_16        32'h0000ffff
`define LANES_32        32'hffffffff
`endif

//--- verilog/cfg_load_pkg.sv
// Purpose: Types shared by the parallel load host.
// Assumes: The map header is on the include path.
// Notes:   All module state lives in one packed struct.
package cfg_load_pkg;
`include "cfg_load_map.svh"
   typedef enum logic [1:0] {W8, W16, W32} bus_width_t;
   typedef enum logic [2:0] {S_IDLE, S_REQ, S_WAIT, S_GAP, S_LOAD, S_TAIL, S_WDONE,
                             S_FIN} st_t;
   typedef struct packed {
      st_t                    st;
      logic [2:0]             init_wait;
      bus_width_t             width;
      logic                   watch;
      logic                   initp;
      logic [3:0]             ratio;
      logic [3:0]             cyc;
      logic [`CNT_W-1:0]      cnt;
      logic [1:0]             ph;
      logic                   clk;
      logic                   req_n;
      logic [31:0]            data;
      logic [31:0]            oe;
      logic                   have;
      logic                   lastw;
      logic                   done;
      logic                   fail;
      logic                   stat1;
      logic                   stat2;
      logic                   cd1;
      logic                   cd2;
      logic                   id1;
      logic                   id2;
      logic [1:0][32:0]       mem;
      logic                   wp;
      logic                   rp;
      logic [1:0]             fcnt;
   } regs_t;
endpackage

//--- verilog/parallel_config_load_port.sv
// Purpose: Host that loads a configuration stream through the passive parallel port.
// Assumes: Load clock is made here from sys_clk; device pins are synchronised.
// Notes:   Load clock runs at sys_clk/4, within the limit of every bus width.
`timescale 1ns/100ps
`include "cfg_load_map.svh"
module parallel_config_load_port
   import cfg_load_pkg::*;
#(
   parameter int REQ_TO_EDGE_CYC = (`REQ_TO_EDGE_US * 1000) / `SYS_PERIOD_NS
)(
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             srst,
   // User orders
   input  wire logic             start,
   input  wire bus_width_t       width_sel,
   input  wire logic             decomp_en,
   input  wire logic             secure_en,
   input  wire logic             watch_status,
   input  wire logic             init_pin_en,
   // User word stream
   input  wire logic [31:0]      in_data,
   input  wire logic             in_last,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // User status
   output logic                  busy,
   output logic                  done,
   output logic                  fail,
   // Device pins
   output logic                  load_clock,
   output logic                  config_request_n,
   output logic [31:0]           data_out,
   output logic [31:0]           data_oe,
   input  wire logic             status_n_in,
   input  wire logic             load_complete_in,
   input  wire logic             init_done_in
);
   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   localparam int REQ_LOW_CYC = (`REQ_LOW_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS;
   localparam int GAP_CYC     = (`STATUS_GAP_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS;
   localparam int FALLS       = `FINAL_FALLS;

   function automatic logic [3:0] ratio_of(bus_width_t w, logic dc, logic sc);
      unique case (w)
         W8:      ratio_of = dc ? 4'h2 : 4'h1;
         W16:     ratio_of = dc ? 4'h4 : (sc ? 4'h2 : 4'h1);
         default: ratio_of = dc ? 4'h8 : (sc ? 4'h4 : 4'h1);
      endcase
   endfunction

   function automatic logic [31:0] lane_mask(bus_width_t w);
      unique case (w)
         W8:      lane_mask = `LANES_8;
         W16:     lane_mask = `LANES_16;
         default: lane_mask = `LANES_32;
      endcase
   endfunction

   regs_t r;
   regs_t n;
   logic  run;
   logic  tick;
   logic  ok;
   logic  rise;
   logic  fall;
   logic  push;
   logic  pop;

   assign in_ready         = (r.fcnt != 2'h2);
   assign busy             = (r.st != S_IDLE);
   assign done             = r.done;
   assign fail             = r.fail;
   assign load_clock       = r.clk;
   assign config_request_n = r.req_n;
   assign data_out         = r.data;
   assign data_oe          = r.oe;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      n     = r;
      run   = 1'b0;
      ok    = 1'b1;
      pop   = 1'b0;
      push  = in_valid && in_ready;
      n.stat1 = status_n_in;
      n.stat2 = r.stat1;
      n.cd1   = load_complete_in;
      n.cd2   = r.cd1;
      n.id1   = init_done_in;
      n.id2   = r.id1;
      if (push) begin
         n.mem[r.wp] = {in_last, in_data};
         n.wp        = ~r.wp;
      end
      unique case (r.st)
         S_LOAD, S_TAIL, S_WDONE, S_FIN: run = 1'b1;
         default:                        run = 1'b0;
      endcase
      // A word is set up only before the first rise of its group, so it holds for all r.
      if (r.st == S_LOAD && !r.clk && !r.have && r.cyc == 4'h0 && r.fcnt != 2'h0) begin
         pop     = 1'b1;
         n.data  = r.mem[r.rp][31:0] & lane_mask(r.width);
         n.lastw = r.mem[r.rp][32];
         n.have  = 1'b1;
         n.rp    = ~r.rp;
      end
      if (r.st == S_LOAD && r.cyc == 4'h0) begin
         ok = r.have;
      end
      tick = (r.ph == 2'(`LOAD_HALF_CYC - 1));
      rise = run && tick && !r.clk && ok;
      fall = run && tick && r.clk;
      if (run) begin
         if (!tick) begin
            n.ph = r.ph + 2'h1;
         end else if (rise || fall) begin
            n.ph  = 2'h0;
            n.clk = rise;
         end
      end
      n.fcnt = r.fcnt + 2'(push) - 2'(pop);
      unique case (r.st)
         S_IDLE: begin
            n.clk = 1'b0;
            if (start) begin
               n.st    = S_REQ;
               n.width = width_sel;
               n.ratio = ratio_of(width_sel, decomp_en, secure_en);
               n.watch = watch_status;
               n.initp = init_pin_en;
               n.req_n = 1'b0;
               n.cnt   = '0;
               n.done  = 1'b0;
               n.fail  = 1'b0;
               n.data  = '0;
            end
         end
         S_REQ: begin
            n.cnt = r.cnt + `CNT_W'(1);
            if (r.cnt == `CNT_W'(REQ_LOW_CYC - 1)) begin
               n.st    = S_WAIT;
               n.req_n = 1'b1;
               n.cnt   = '0;
            end
         end
         S_WAIT: begin
            n.cnt = r.cnt + `CNT_W'(1);
            if (r.watch && r.stat2) begin
               n.st  = S_GAP;
               n.cnt = '0;
            end else if (!r.watch && r.cnt == `CNT_W'(REQ_TO_EDGE_CYC - 1)) begin
               n.st   = S_LOAD;
               n.oe   = lane_mask(r.width);
               n.cyc  = 4'h0;
               n.have = 1'b0;
               n.ph   = 2'h0;
            end
         end
         S_GAP: begin
            n.cnt = r.cnt + `CNT_W'(1);
            if (r.cnt == `CNT_W'(GAP_CYC - 1)) begin
               n.st   = S_LOAD;
               n.oe   = lane_mask(r.width);
               n.cyc  = 4'h0;
               n.have = 1'b0;
               n.ph   = 2'h0;
            end
         end
         S_LOAD: begin
            if (rise) begin
               n.cyc = (r.cyc == r.ratio - 4'h1) ? 4'h0 : r.cyc + 4'h1;
               if (r.cyc == 4'h0) begin
                  n.have = 1'b0;
                  if (r.lastw) begin
                     n.st  = (r.ratio == 4'h1) ? S_WDONE : S_TAIL;
                     n.cnt = `CNT_W'(r.ratio - 4'h1);
                  end
               end
            end
         end
         S_TAIL: begin
            if (rise) begin
               n.cnt = r.cnt - `CNT_W'(1);
               if (r.cnt == `CNT_W'(1)) begin
                  n.st = S_WDONE;
               end
            end
         end
         S_WDONE: begin
            if (r.cd2) begin
               n.st  = S_FIN;
               n.cnt = '0;
            end
         end
         S_FIN: begin
            if (fall) begin
               n.cnt = r.cnt + `CNT_W'(1);
               if (r.cnt == `CNT_W'(FALLS - 1)) begin
                  n.st        = S_IDLE;
                  n.oe        = '0;
                  n.init_wait = {2'h0, r.initp};
                  n.done      = !r.initp;
               end
            end
         end
      endcase
      // The init-done pin is watched after the clock stops; the clock is not needed.
      if (r.init_wait[0] && r.id2) begin
         n.init_wait = 3'h0;
         n.done      = 1'b1;
      end
      // Status falling mid-load is the device reporting a bad stream.
      if (run && r.watch && !r.stat2) begin
         n.st   = S_IDLE;
         n.fail = 1'b1;
         n.oe   = '0;
         n.clk  = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         r       <= '0;
         r.st    <= S_IDLE;
         r.req_n <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_req_width: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(config_request_n) |-> $past(r.cnt) == `CNT_W'(REQ_LOW_CYC - 1))
      else $error("request low too short");
   a_gap_before_rise: assert property (@(posedge sys_clk) disable iff (srst)
      ($past(r.st) == S_GAP && r.st == S_LOAD) |-> $past(r.cnt) == `CNT_W'(GAP_CYC - 1))
      else $error("first rise too early after status");
   a_word_hold: assert property (@(posedge sys_clk) disable iff (srst)
      (r.st == S_LOAD && $past(r.st) == S_LOAD && r.cyc != 4'h0) |-> $stable(data_out))
      else $error("data changed inside a word");
   a_lane_mask: assert property (@(posedge sys_clk) disable iff (srst)
      ((data_out & ~lane_mask(r.width)) == 32'h0) && ((data_oe & ~lane_mask(r.width)) == 32'h0))
      else $error("unused lane driven");
   a_clock_high: assert property (@(posedge sys_clk) disable iff (srst)
      ($rose(load_clock) && r.st != S_IDLE) |-> load_clock[*2])
      else $error("load clock high phase too short");
   a_pause_low: assert property (@(posedge sys_clk) disable iff (srst)
      ($rose(load_clock) && $past(r.st) == S_LOAD && $past(r.cyc) == 4'h0) |-> $past(r.have))
      else $error("rise without data set up");
   a_tail_count: assert property (@(posedge sys_clk) disable iff (srst)
      ($past(r.st) == S_TAIL && r.st == S_WDONE) |-> $past(r.cnt) == `CNT_W'(1) && $rose(load_clock))
      else $error("tail clocks wrong");
   a_two_falls: assert property (@(posedge sys_clk) disable iff (srst)
      ($past(r.st) == S_FIN && r.st == S_IDLE && !fail) |-> $fell(load_clock)
         && $past(r.cnt) == `CNT_W'(FALLS - 1))
      else $error("final falling edges wrong");
   a_idle_level: assert property (@(posedge sys_clk) disable iff (srst)
      (r.st == S_IDLE) |=> (!load_clock || r.st != S_IDLE) && (data_oe == 32'h0 || r.st != S_IDLE))
      else $error("clock or data left driven at idle");
endmodule

//--- testbench/cfg_device_model.sv
// Purpose: Behavioural device on the far side of the parallel load port.
// Assumes: Times are shortened; the bench tells it the clocks-per-word ratio.
// Notes:   Rising edges seen while status is low or after completion are ignored; falls after completion are counted.
`timescale 1ns/100ps
module cfg_device_model #(
   parameter int N_WORDS = 4,
   parameter int STAT_NS = 122,
   parameter int INIT_NS = 202
)(
   // Host pins
   input  wire logic        load_clock,
   input  wire logic        config_request_n,
   input  wire logic [31:0] data_out,
   // Bench controls
   input  wire logic [3:0]  ratio,
   input  wire logic        fault,
   // Device pins
   output logic             status_n,
   output logic             load_complete,
   output logic             init_done
);
   logic        status_r = 1'b0;
   logic [31:0] got [0:7];
   int          nw = 0, ph = 0, falls = 0;
   realtime     t_req, t_st, t_first;
   // A fault pulls the open-drain status line low, as a failed load would.
   assign status_n = status_r & ~fault;
   initial begin
      load_complete = 1'b0;
      init_done = 1'b0;
   end
   always @(negedge config_request_n) begin
      #102;
      status_r = 1'b0;
      load_complete = 1'b0;
      init_done = 1'b0;
      nw = 0;
      ph = 0;
      falls = 0;
   end
   always @(posedge config_request_n) begin
      t_req = $realtime;
      #(STAT_NS);
      status_r = 1'b1;
      t_st = $realtime;
   end
   always @(posedge load_clock) begin
      if (status_n && !load_complete) begin
         if (ph == 0) begin
            if (nw == 0) t_first = $realtime;
            if (nw < 8) got[nw] = data_out;
            nw++;
         end
         ph = (ph + 1 == ratio) ? 0 : ph + 1;
         if (nw == N_WORDS && ph == 0) load_complete = 1'b1;
      end
   end
   always @(negedge load_clock) begin
      if (load_complete) falls++;
      // INIT_NS stands for either source of the initialization clock.
      if (load_complete && falls == 2) init_done <= #(INIT_NS) 1'b1;
   end
endmodule

//--- testbench/parallel_config_load_port_bench.sv
// Purpose: Self-checking bench of the parallel load host.
// Assumes: Device model with short status and init delays.
// Notes:   Blind wait is cut to 50 cycles, still longer than the model's status delay.
`timescale 1ns/100ps
module parallel_config_load_port_bench;
   import cfg_load_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        sys_clk = 0, srst = 1, start = 0, decomp_en = 0, secure_en = 0;
   logic        watch_status = 0, init_pin_en = 0, in_last = 0, in_valid = 0, fault = 0;
   bus_width_t  width_sel = W8;
   logic [31:0] in_data = '0;
   logic [3:0]  m_ratio = 4'h1;
   wire         in_ready, busy, done, fail, load_clock, config_request_n;
   wire         status_n, load_complete, init_done;
   wire  [31:0] data_out, data_oe;
   logic [31:0] exp_w [0:3];
   int          errors = 0, check_count = 0;

   parallel_config_load_port #(.REQ_TO_EDGE_CYC(50)) i_parallel_config_load_port (
      .sys_clk(sys_clk), .srst(srst), .start(start), .width_sel(width_sel),
      .decomp_en(decomp_en), .secure_en(secure_en), .watch_status(watch_status),
      .init_pin_en(init_pin_en), .in_data(in_data), .in_last(in_last),
      .in_valid(in_valid), .in_ready(in_ready), .busy(busy), .done(done), .fail(fail),
      .load_clock(load_clock), .config_request_n(config_request_n), .data_out(data_out),
      .data_oe(data_oe), .status_n_in(status_n), .load_complete_in(load_complete),
      .init_done_in(init_done));
   cfg_device_model i_cfg_device_model (
      .load_clock(load_clock), .config_request_n(config_request_n), .data_out(data_out),
      .ratio(m_ratio), .fault(fault), .status_n(status_n),
      .load_complete(load_complete), .init_done(init_done));

   always #2 sys_clk = ~sys_clk;
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [3:0] ratio_of(input bus_width_t w, input logic dc, sc);
      case (w)
         W8:      return dc ? 4'h2 : 4'h1;
         W16:     return dc ? 4'h4 : (sc ? 4'h2 : 4'h1);
         default: return dc ? 4'h8 : (sc ? 4'h4 : 4'h1);
      endcase
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // The word is held until a cycle in which the buffer had room.
   task automatic push(input logic [31:0] d, input logic last);
      logic r;
      int   n;
      n = 0;
      @(negedge sys_clk);
      in_data = d;
      in_last = last;
      in_valid = 1'b1;
      do begin
         r = in_ready;
         @(posedge sys_clk);
         if (r !== 1'b1) @(negedge sys_clk);
         n++;
      end while (r !== 1'b1 && n < 50000);
      check(r, 1'b1);
   endtask
   task automatic run_load(input bus_width_t w, input logic dc, sc, wt, ip, flt);
      int          n;
      logic [31:0] m;
      m = (w == W8) ? 32'h000000ff : (w == W16) ? 32'h0000ffff : 32'hffffffff;
      m_ratio = ratio_of(w, dc, sc);
      for (int k = 0; k < 4; k++) exp_w[k] = $urandom;
      push(exp_w[0], 1'b0);
      push(exp_w[1], 1'b0);
      @(negedge sys_clk);
      in_valid = 1'b0;
      check(in_ready, 0);
      width_sel = w;
      decomp_en = dc;
      secure_en = sc;
      watch_status = wt;
      init_pin_en = ip;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      n = 0;
      while (config_request_n !== 1'b0 && n < 8) begin
         @(negedge sys_clk);
         n++;
      end
      n = 0;
      while (config_request_n === 1'b0 && n < 2000) begin
         @(negedge sys_clk);
         n++;
      end
      check(n, 500);
      if (flt) begin
         n = 0;
         while (i_cfg_device_model.nw < 2 && n < 20000) begin
            @(negedge sys_clk);
            n++;
         end
         fault = 1'b1;
      end else begin
         push(exp_w[2], 1'b0);
         @(negedge sys_clk);
         in_valid = 1'b0;
         check(data_oe, m);
         repeat ($urandom % 40) @(negedge sys_clk);
         push(exp_w[3], 1'b1);
         @(negedge sys_clk);
         in_valid = 1'b0;
      end
      n = 0;
      while (done !== 1'b1 && fail !== 1'b1 && n < 40000) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      check(fail, flt);
      check(done, !flt);
      check(data_oe, 0);
      check({load_clock, busy}, 0);
      if (!flt) begin
         for (int k = 0; k < 4; k++) check(i_cfg_device_model.got[k], exp_w[k] & m);
         // The fall after the completing rise lands before the host has synchronised the flag.
         check(i_cfg_device_model.falls, 3);
         check({config_request_n, status_n, load_complete}, 3'h7);
         check(init_done | !ip, 1);
         check(wt ? (i_cfg_device_model.t_first - i_cfg_device_model.t_st >= 2000.0) :
               (i_cfg_device_model.t_first - i_cfg_device_model.t_req >= 200.0), 1);
      end
      fault = 1'b0;
      repeat (100) @(negedge sys_clk);
   endtask
   task automatic final_report();
      if (errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'h5477));
      repeat (6) @(negedge sys_clk);
      srst = 1'b0;
      check({busy, done, fail, config_request_n, load_clock}, 5'h02);
      for (int i = 0; i < 12; i++)
         run_load(bus_width_t'(i / 4), i[1], i[0], (i % 3) != 0, 1'($urandom), 1'b0);
      run_load(W16, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
      final_report();
   end
   // A hang is cut short well beyond the expected run of about 15k cycles.
   initial begin
      #400000;
      errors++;
      final_report();
   end
endmodule
